// ### rtl/jtag_flash_pkg.sv
package jtag_flash_pkg;

	// ==========================================
	// Scan path geometry
	localparam int          IR_W      = 16;
	localparam int          IND_W     = 20;
	localparam int          ID_W      = 32;
	localparam logic [15:0] IR_RESET  = 16'h0001;
	localparam logic [15:0] IR_IDCODE = 16'h0004;
	localparam logic [15:0] IR_FL_CON = 16'h0082;
	localparam logic [15:0] IR_FL_DAT = 16'h0083;
	localparam logic [15:0] IR_FL_ADR = 16'h0084;

	// ==========================================
	// Indirect command and response fields
	localparam int         OP_HI     = 19;
	localparam int         OP_LO     = 18;
	localparam int         PAY_HI    = 17;
	localparam int         PAY_W     = 18;
	localparam logic [1:0] OP_READ   = 2'h2;
	localparam logic [1:0] OP_WRITE  = 2'h3;
	localparam logic       RSP_TOP   = 1'b0;
	localparam int         PAD_W     = ID_W - IND_W;

	// ==========================================
	// Flash control modes and values
	localparam logic [2:0]  WM_STORE   = 3'h0;
	localparam logic [2:0]  WM_PROG    = 3'h1;
	localparam logic [2:0]  WM_ERASE   = 3'h2;
	localparam logic [3:0]  RM_PLAIN   = 4'h0;
	localparam logic [3:0]  RM_BLOCK   = 4'h1;
	localparam logic [3:0]  RM_SINGLE  = 4'h2;
	localparam logic [7:0]  ERASE_KEY  = 8'ha5;
	localparam logic [7:0]  CON_RESET  = 8'h00;
	localparam logic [7:0]  DAT_RESET  = 8'h00;
	localparam logic [15:0] ADR_RESET  = 16'h0000;
	localparam logic [15:0] ADR_STEP   = 16'h0001;
	localparam logic [15:0] LOCK_RD    = 16'hfdff;
	localparam logic [15:0] LOCK_WR    = 16'hfdfe;

	// ==========================================
	// Identification fields, values arbitrary
	localparam logic [3:0]  ID_VERSION = 4'h1;
	localparam logic [15:0] ID_PART    = 16'h0a3c;
	localparam logic [10:0] ID_MAKER   = 11'h15a;
	localparam logic        ID_MARK    = 1'b1;

	typedef enum logic [1:0] {
		FC_READ      = 2'h0,
		FC_PROG      = 2'h1,
		FC_ERASE     = 2'h2,
		FC_ERASE_ALL = 2'h3
	} flash_cmd_t;

	typedef struct packed {
		flash_cmd_t  cmd;
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        scratch;
	} flash_req_t;

	typedef struct packed {
		logic       ack;
		logic       fail;
		logic [7:0] rdata;
	} flash_rsp_t;

	typedef struct packed {
		logic       scratch;
		logic [2:0] wmode;
		logic [3:0] rmode;
	} flash_ctrl_t;

	typedef struct packed {
		logic [7:0] data;
		logic       fail;
		logic       busy;
	} flash_dat_t;

	typedef enum logic [15:0] {
		T_RESET = 16'h0001, T_IDLE  = 16'h0002, T_SELDR = 16'h0004, T_CAPDR = 16'h0008,
		T_SHDR  = 16'h0010, T_EX1DR = 16'h0020, T_PSDR  = 16'h0040, T_EX2DR = 16'h0080,
		T_UPDR  = 16'h0100, T_SELIR = 16'h0200, T_CAPIR = 16'h0400, T_SHIR  = 16'h0800,
		T_EX1IR = 16'h1000, T_PSIR  = 16'h2000, T_EX2IR = 16'h4000, T_UPIR  = 16'h8000
	} tap_state_t;

endpackage : jtag_flash_pkg

// ### rtl/bit_sync.sv
`timescale 1ns/10ps
`default_nettype none

module bit_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule : bit_sync

`default_nettype wire

// ### rtl/flash_op_engine.sv
`timescale 1ns/10ps
`default_nettype none

module flash_op_engine (
	input  wire logic                      clk,
	input  wire logic                      rstn,
	input  wire logic                      start,
	input  wire jtag_flash_pkg::flash_req_t start_req,
	output logic                           busy,
	output logic                           done,
	output logic                           flash_valid,
	output jtag_flash_pkg::flash_req_t      flash_req,
	input  wire jtag_flash_pkg::flash_rsp_t flash_rsp
);

	typedef enum logic [1:0] {
		E_IDLE = 2'b01,
		E_WAIT = 2'b10
	} eng_state_t;

	eng_state_t state_q;

	// ==========================================
	// One request outstanding at a time
	assign busy        = (state_q == E_WAIT);
	assign flash_valid = busy;
	assign done        = busy && flash_rsp.ack;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q   <= E_IDLE;
			flash_req <= '0;
		end else begin
			unique case (state_q)
				E_IDLE: begin
					if (start) begin
						state_q   <= E_WAIT;
						flash_req <= start_req;
					end
				end
				E_WAIT: begin
					if (flash_rsp.ack) begin
						state_q <= E_IDLE;
					end
				end
			endcase
		end
	end

	a_busy_till_ack: // [R9]
	assert property (@(posedge clk) disable iff (!rstn)
		(start && !busy) || (busy && !done) |=> busy)
	else $error("Engine busy dropped before flash acknowledge");

endmodule : flash_op_engine

`default_nettype wire

// ### rtl/jtag_flash_access.sv
// How it works
// (R1) Command: opcode bits 19:18, payload 17:0
// (R2) Opcode 0x poll, 10 read, 11 write
// (R3) Poll captures status, never updates
// (R4) Two shifted opcode bits start a read
// (R5) Tester left-justifies short payloads at bit 17
// (R6) Tester polls busy before using results
// (R7) Tester keeps instruction fixed while busy
// (R8) Response: zero, 18-bit payload, busy
// (R9) Busy high from start until completion
// (R10) Commands while busy wait for busy low
// (R11) Read payload right-justified behind busy
// (R12) Control top bit selects scratchpad sector
// (R13) Tester keeps scratchpad addresses in range
// (R14) Write mode 000 only stores data
// (R15) Write mode 001 programs, then address+1
// (R16) Write mode 010 erases page on key
// (R17) Lock byte address erases whole user space
// (R18) Read mode 0000 returns stored data
// (R19) Read mode 0001 reads whenever idle
// (R20) Read mode 0010 needs prior result fetched
// (R21) Tester uses only defined mode encodings
// (R22) Identification: version, part, maker fields
// (R23) Identification instruction selects 32-bit register
// (R24) Data register: byte, fail, busy; a read returns only the byte, and fail_q is never read out
// (R25) Read byte loaded before busy clears
`timescale 1ns/10ps
`default_nettype none

module jtag_flash_access (
	input  wire logic                      sys_clk,
	input  wire logic                      rstn,
	input  wire logic                      tck,
	input  wire logic                      tms,
	input  wire logic                      tdi,
	output logic                           tdo,
	output logic                           tdo_en_n,
	output logic                           flash_valid,
	output jtag_flash_pkg::flash_req_t      flash_req,
	input  wire jtag_flash_pkg::flash_rsp_t flash_rsp
);

	// ==========================================
	// Pin sampling
	logic [2:0] pins_s;
	logic       tck_s;
	logic       tms_s;
	logic       tdi_s;
	logic       tck_prev_q;
	logic       tck_rise;
	logic       tck_fall;

	bit_sync #(
		.W (3)
	) u_pin_sync (
		.clk      (sys_clk),
		.rstn     (rstn),
		.async_in ({tck, tms, tdi}),
		.sync_out (pins_s)
	);

	assign tck_s    = pins_s[2];
	assign tms_s    = pins_s[1];
	assign tdi_s    = pins_s[0];
	assign tck_rise = tck_s && !tck_prev_q;
	assign tck_fall = !tck_s && tck_prev_q;

	// ==========================================
	// Test access port controller
	jtag_flash_pkg::tap_state_t state_q;
	jtag_flash_pkg::tap_state_t state_d;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			jtag_flash_pkg::T_RESET: state_d = tms_s ? jtag_flash_pkg::T_RESET : jtag_flash_pkg::T_IDLE;
			jtag_flash_pkg::T_IDLE:  state_d = tms_s ? jtag_flash_pkg::T_SELDR : jtag_flash_pkg::T_IDLE;
			jtag_flash_pkg::T_SELDR: state_d = tms_s ? jtag_flash_pkg::T_SELIR : jtag_flash_pkg::T_CAPDR;
			jtag_flash_pkg::T_CAPDR: state_d = tms_s ? jtag_flash_pkg::T_EX1DR : jtag_flash_pkg::T_SHDR;
			jtag_flash_pkg::T_SHDR:  state_d = tms_s ? jtag_flash_pkg::T_EX1DR : jtag_flash_pkg::T_SHDR;
			jtag_flash_pkg::T_EX1DR: state_d = tms_s ? jtag_flash_pkg::T_UPDR : jtag_flash_pkg::T_PSDR;
			jtag_flash_pkg::T_PSDR:  state_d = tms_s ? jtag_flash_pkg::T_EX2DR : jtag_flash_pkg::T_PSDR;
			jtag_flash_pkg::T_EX2DR: state_d = tms_s ? jtag_flash_pkg::T_UPDR : jtag_flash_pkg::T_SHDR;
			jtag_flash_pkg::T_UPDR:  state_d = tms_s ? jtag_flash_pkg::T_SELDR : jtag_flash_pkg::T_IDLE;
			jtag_flash_pkg::T_SELIR: state_d = tms_s ? jtag_flash_pkg::T_RESET : jtag_flash_pkg::T_CAPIR;
			jtag_flash_pkg::T_CAPIR: state_d = tms_s ? jtag_flash_pkg::T_EX1IR : jtag_flash_pkg::T_SHIR;
			jtag_flash_pkg::T_SHIR:  state_d = tms_s ? jtag_flash_pkg::T_EX1IR : jtag_flash_pkg::T_SHIR;
			jtag_flash_pkg::T_EX1IR: state_d = tms_s ? jtag_flash_pkg::T_UPIR : jtag_flash_pkg::T_PSIR;
			jtag_flash_pkg::T_PSIR:  state_d = tms_s ? jtag_flash_pkg::T_EX2IR : jtag_flash_pkg::T_PSIR;
			jtag_flash_pkg::T_EX2IR: state_d = tms_s ? jtag_flash_pkg::T_UPIR : jtag_flash_pkg::T_SHIR;
			jtag_flash_pkg::T_UPIR:  state_d = tms_s ? jtag_flash_pkg::T_SELDR : jtag_flash_pkg::T_IDLE;
			default:                 state_d = jtag_flash_pkg::T_RESET;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_q    <= jtag_flash_pkg::T_RESET;
			tck_prev_q <= 1'b0;
		end else begin
			tck_prev_q <= tck_s;
			if (tck_rise) begin
				state_q <= state_d;
			end
		end
	end

	// ==========================================
	// Step strobes and instruction decode
	logic [15:0] ir_q;
	logic [15:0] ir_sr_q;
	logic [31:0] dr_sr_q;
	logic        in_reset;
	logic        cap_ir;
	logic        sh_ir;
	logic        up_ir;
	logic        cap_dr;
	logic        sh_dr;
	logic        up_dr;
	logic        sel_con;
	logic        sel_dat;
	logic        sel_adr;
	logic        sel_ind;
	logic        sel_id;

	assign in_reset = (state_q == jtag_flash_pkg::T_RESET);
	assign cap_ir   = tck_rise && (state_q == jtag_flash_pkg::T_CAPIR);
	assign sh_ir    = tck_rise && (state_q == jtag_flash_pkg::T_SHIR);
	assign up_ir    = tck_rise && (state_q == jtag_flash_pkg::T_UPIR);
	assign cap_dr   = tck_rise && (state_q == jtag_flash_pkg::T_CAPDR);
	assign sh_dr    = tck_rise && (state_q == jtag_flash_pkg::T_SHDR);
	assign up_dr    = tck_rise && (state_q == jtag_flash_pkg::T_UPDR);
	assign sel_con  = (ir_q == jtag_flash_pkg::IR_FL_CON);
	assign sel_dat  = (ir_q == jtag_flash_pkg::IR_FL_DAT);
	assign sel_adr  = (ir_q == jtag_flash_pkg::IR_FL_ADR);
	assign sel_ind  = sel_con || sel_dat || sel_adr;
	assign sel_id   = (ir_q == jtag_flash_pkg::IR_IDCODE); // [R23]

	// ==========================================
	// Flash interface registers
	jtag_flash_pkg::flash_ctrl_t con_q;
	jtag_flash_pkg::flash_dat_t  dat_view;
	jtag_flash_pkg::flash_req_t  eng_req;
	logic [7:0]                  dat_q;
	logic                        fail_q;
	logic [15:0]                 adr_q;
	logic [17:0]                 rd_res_q;
	logic                        unread_q;
	logic                        pend_q;
	logic [19:0]                 pend_cmd_q;
	logic                        busy;
	logic                        eng_done;

	assign dat_view = '{data: dat_q, fail: fail_q, busy: busy}; // [R24]

	// ==========================================
	// Command decode and launch
	logic [19:0] cmd;
	logic [1:0]  cmd_op;
	logic [7:0]  pay_byte;
	logic [15:0] pay_word;
	logic        cmd_rw;
	logic        exec_go;
	logic        exec_rd;
	logic        exec_wr;
	logic        wr_dat;
	logic        rd_dat;
	logic        lock_hit;
	logic        start_prog;
	logic        start_erase;
	logic        start_read;
	logic        eng_start;
	logic [17:0] rd_value;

	// A poll leaves bit 19 low, so it never counts as read or write
	assign cmd      = (cap_dr && pend_q) ? pend_cmd_q : dr_sr_q[19:0];
	assign cmd_op   = cmd[jtag_flash_pkg::OP_HI:jtag_flash_pkg::OP_LO]; // [R1]
	assign pay_byte = cmd[jtag_flash_pkg::PAY_HI -: 8];
	assign pay_word = cmd[jtag_flash_pkg::PAY_HI -: 16];
	assign cmd_rw   = (cmd_op == jtag_flash_pkg::OP_READ)
		|| (cmd_op == jtag_flash_pkg::OP_WRITE); // [R2]
	// Commands during busy are held and launched at the next idle capture
	assign exec_go  = sel_ind && !busy && ((up_dr && cmd_rw) || (cap_dr && pend_q)); // [R10]
	assign exec_rd  = exec_go && (cmd_op == jtag_flash_pkg::OP_READ); // [R4]
	assign exec_wr  = exec_go && (cmd_op == jtag_flash_pkg::OP_WRITE);
	assign wr_dat   = exec_wr && sel_dat;
	assign rd_dat   = exec_rd && sel_dat;
	assign lock_hit = (adr_q == jtag_flash_pkg::LOCK_RD) || (adr_q == jtag_flash_pkg::LOCK_WR);

	assign start_prog  = wr_dat && (con_q.wmode == jtag_flash_pkg::WM_PROG); // [R15]
	assign start_erase = wr_dat && (con_q.wmode == jtag_flash_pkg::WM_ERASE)
		&& (pay_byte == jtag_flash_pkg::ERASE_KEY); // [R16]
	assign start_read  = rd_dat && ((con_q.rmode == jtag_flash_pkg::RM_BLOCK)
		|| ((con_q.rmode == jtag_flash_pkg::RM_SINGLE) && !unread_q)); // [R19] [R20]
	assign eng_start   = start_prog || start_erase || start_read;

	assign eng_req.cmd     = start_read ? jtag_flash_pkg::FC_READ
		: start_prog ? jtag_flash_pkg::FC_PROG
		: lock_hit ? jtag_flash_pkg::FC_ERASE_ALL // [R17]
		: jtag_flash_pkg::FC_ERASE;
	assign eng_req.addr    = adr_q;
	assign eng_req.wdata   = pay_byte;
	assign eng_req.scratch = con_q.scratch; // [R12]

	// Short registers come back right-justified behind busy
	assign rd_value = sel_con ? {10'h000, con_q}
		: sel_adr ? {2'h0, adr_q}
		: {10'h000, dat_view.data}; // [R11] [R18]

	flash_op_engine u_engine (
		.clk         (sys_clk),
		.rstn        (rstn),
		.start       (eng_start),
		.start_req   (eng_req),
		.busy        (busy),
		.done        (eng_done),
		.flash_valid (flash_valid),
		.flash_req   (flash_req),
		.flash_rsp   (flash_rsp)
	); // [R9]

	// ==========================================
	// Register updates
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			con_q      <= jtag_flash_pkg::CON_RESET;
			dat_q      <= jtag_flash_pkg::DAT_RESET;
			adr_q      <= jtag_flash_pkg::ADR_RESET;
			fail_q     <= 1'b0;
			unread_q   <= 1'b0;
			rd_res_q   <= '0;
		end else begin
			if (exec_wr && sel_con) begin
				con_q <= jtag_flash_pkg::flash_ctrl_t'(pay_byte);
			end
			if (exec_wr && sel_adr) begin
				adr_q <= pay_word;
			end
			if (wr_dat) begin
				dat_q <= pay_byte; // [R14]
			end
			if (exec_rd) begin
				rd_res_q <= rd_value;
			end
			if (rd_dat) begin
				unread_q <= 1'b0;
			end
			if (eng_done) begin
				fail_q <= flash_rsp.fail;
				if (flash_req.cmd == jtag_flash_pkg::FC_READ) begin
					dat_q    <= flash_rsp.rdata; // [R25]
					unread_q <= 1'b1;
				end
				if (flash_req.cmd == jtag_flash_pkg::FC_READ
					|| flash_req.cmd == jtag_flash_pkg::FC_PROG) begin
					adr_q <= adr_q + jtag_flash_pkg::ADR_STEP; // [R15]
				end
			end
		end
	end

	// ==========================================
	// Deferred command holding
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pend_q     <= 1'b0;
			pend_cmd_q <= '0;
		end else if (in_reset || exec_go) begin
			pend_q <= 1'b0;
		end else if (up_dr && sel_ind && cmd_rw && busy) begin
			pend_q     <= 1'b1; // [R10]
			pend_cmd_q <= dr_sr_q[19:0];
		end
	end

	// ==========================================
	// Instruction and data shift paths
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ir_q    <= jtag_flash_pkg::IR_IDCODE;
			ir_sr_q <= '0;
		end else if (tck_rise && in_reset) begin
			ir_q <= jtag_flash_pkg::IR_IDCODE;
		end else if (cap_ir) begin
			ir_sr_q <= jtag_flash_pkg::IR_RESET;
		end else if (sh_ir) begin
			ir_sr_q <= {tdi_s, ir_sr_q[15:1]};
		end else if (up_ir) begin
			ir_q <= ir_sr_q;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			dr_sr_q <= '0;
		end else if (cap_dr) begin
			if (sel_id) begin
				dr_sr_q <= {jtag_flash_pkg::ID_VERSION, jtag_flash_pkg::ID_PART,
					jtag_flash_pkg::ID_MAKER, jtag_flash_pkg::ID_MARK}; // [R22]
			end else if (sel_ind) begin
				dr_sr_q <= {{jtag_flash_pkg::PAD_W{1'b0}}, jtag_flash_pkg::RSP_TOP,
					rd_res_q, busy}; // [R3] [R8]
			end else begin
				dr_sr_q <= '0;
			end
		end else if (sh_dr) begin
			if (sel_id) begin
				dr_sr_q <= {tdi_s, dr_sr_q[31:1]};
			end else if (sel_ind) begin
				// Tester's last bits land in 19:18, payload MSB at 17
				dr_sr_q <= {{jtag_flash_pkg::PAD_W{1'b0}}, tdi_s, dr_sr_q[19:1]};
			end else begin
				dr_sr_q <= {31'h00000000, tdi_s};
			end
		end
	end

	// ==========================================
	// Serial output, changed on the falling test clock edge
	logic shifting;

	assign shifting = (state_q == jtag_flash_pkg::T_SHDR) || (state_q == jtag_flash_pkg::T_SHIR);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			tdo      <= 1'b0;
			tdo_en_n <= 1'b1;
		end else if (tck_fall) begin
			tdo      <= (state_q == jtag_flash_pkg::T_SHIR) ? ir_sr_q[0] : dr_sr_q[0];
			tdo_en_n <= !shifting;
		end
	end

	// ==========================================
	// Checks
	a_poll_no_write: // [R3]
	assert property (@(posedge sys_clk) disable iff (!rstn)
		up_dr && sel_ind && !dr_sr_q[jtag_flash_pkg::OP_HI] |=> $stable(con_q) && $stable(adr_q)
			&& $stable(dat_q) && !busy || $past(busy))
	else $error("Poll changed a register");

	a_resp_layout: // [R8]
	assert property (@(posedge sys_clk) disable iff (!rstn)
		cap_dr && sel_ind |=> dr_sr_q[19] == 1'b0 && dr_sr_q[0] == $past(busy)
			&& dr_sr_q[18:1] == $past(rd_res_q))
	else $error("Indirect response layout wrong");

	a_busy_ignore: // [R10]
	assert property (@(posedge sys_clk) disable iff (!rstn)
		busy && up_dr |-> !eng_start ##1 $stable(con_q) && ($stable(adr_q) || $past(eng_done)))
	else $error("Command acted while busy");

	a_mode_store: // [R14]
	assert property (@(posedge sys_clk) disable iff (!rstn)
		wr_dat && con_q.wmode == jtag_flash_pkg::WM_STORE |-> !eng_start ##1 dat_q == $past(pay_byte))
	else $error("Store mode started a flash operation");

	a_prog_incr: // [R15]
	assert property (@(posedge sys_clk) disable iff (!rstn)
		eng_done && flash_req.cmd == jtag_flash_pkg::FC_PROG
		|=> adr_q == $past(adr_q) + jtag_flash_pkg::ADR_STEP)
	else $error("Address not stepped after program");

	a_erase_key: // [R16]
	assert property (@(posedge sys_clk) disable iff (!rstn)
		eng_start && eng_req.cmd != jtag_flash_pkg::FC_READ && con_q.wmode == jtag_flash_pkg::WM_ERASE
		|-> pay_byte == jtag_flash_pkg::ERASE_KEY ##1 busy && $stable(adr_q))
	else $error("Erase without key");

	a_single_read: // [R20]
	assert property (@(posedge sys_clk) disable iff (!rstn)
		start_read && con_q.rmode == jtag_flash_pkg::RM_SINGLE |-> !unread_q && !busy)
	else $error("Single read started over unread data");

	a_read_loads: // [R25]
	assert property (@(posedge sys_clk) disable iff (!rstn)
		eng_done && flash_req.cmd == jtag_flash_pkg::FC_READ
		|=> dat_q == $past(flash_rsp.rdata) && !busy && unread_q)
	else $error("Read byte not loaded at completion");

	a_id_capture: // [R22]
	assert property (@(posedge sys_clk) disable iff (!rstn)
		cap_dr && sel_id |=> dr_sr_q[31:28] == jtag_flash_pkg::ID_VERSION
			&& dr_sr_q[27:12] == jtag_flash_pkg::ID_PART)
	else $error("Identification capture wrong");

	a_scratch_route: // [R12]
	assert property (@(posedge sys_clk) disable iff (!rstn)
		eng_start |=> flash_valid && flash_req.scratch == $past(con_q.scratch))
	else $error("Scratchpad select not carried");

endmodule : jtag_flash_access

`default_nettype wire

// ### verification/flash_model.sv
`timescale 1ns/10ps
`default_nettype none

module flash_model (
	input  wire logic                       clk,
	input  wire logic                       rstn,
	input  wire logic [7:0]                 delay,
	input  wire logic                       flash_valid,
	input  wire jtag_flash_pkg::flash_req_t flash_req,
	output jtag_flash_pkg::flash_rsp_t      flash_rsp
);
	// ==========================================
	// Byte store, low address byte only
	logic [7:0]                 mem [256];
	logic [8:0]                 wait_q;
	logic                       pend_q;
	jtag_flash_pkg::flash_req_t last_req;
	int                         req_cnt;

	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i * 7);
		end
		req_cnt = 0;
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flash_rsp <= '0;
			pend_q    <= 1'b0;
			wait_q    <= 9'h000;
		end else begin
			flash_rsp.ack   <= 1'b0;
			// Stale data flips, never looks valid
			flash_rsp.rdata <= ~flash_rsp.rdata;
			if (flash_valid && !pend_q && !flash_rsp.ack) begin
				pend_q   <= 1'b1;
				wait_q   <= {1'b0, delay} + 9'h040;
				last_req <= flash_req;
				req_cnt  <= req_cnt + 1;
			end else if (pend_q && wait_q != 9'h000) begin
				wait_q <= wait_q - 9'h001;
			end else if (pend_q) begin
				pend_q        <= 1'b0;
				flash_rsp.ack <= 1'b1;
				case (last_req.cmd)
					jtag_flash_pkg::FC_READ: flash_rsp.rdata <= mem[last_req.addr[7:0]];
					jtag_flash_pkg::FC_PROG: mem[last_req.addr[7:0]] <= last_req.wdata;
					default: for (int i = 0; i < 256; i++) mem[i] <= 8'hff;
				endcase
			end
		end
	end
endmodule : flash_model

`default_nettype wire

// ### verification/test_jtag_flash_access.sv
`timescale 1ns/10ps
`default_nettype none

module test_jtag_flash_access;
	localparam logic [15:0] CON = jtag_flash_pkg::IR_FL_CON;
	localparam logic [15:0] DAT = jtag_flash_pkg::IR_FL_DAT;
	localparam logic [15:0] ADR = jtag_flash_pkg::IR_FL_ADR;

	logic                       sys_clk = 1'b0;
	logic                       rstn = 1'b0;
	logic                       tck = 1'b0;
	logic                       tms = 1'b1;
	logic                       tdi = 1'b0;
	logic [7:0]                 delay = 8'h00;
	logic                       tdo;
	logic                       tdo_en_n;
	logic                       flash_valid;
	jtag_flash_pkg::flash_req_t flash_req;
	jtag_flash_pkg::flash_rsp_t flash_rsp;
	int                         error_cnt = 0;
	int                         tests_run = 0;
	int                         n0;
	logic [31:0]                rnd = 32'h8eb4;
	logic [31:0]                exp_q [$];
	logic [31:0]                seen;
	logic [31:0]                o;
	logic                       busy1;
	logic [7:0]                 b0;
	logic [7:0]                 b1;
	event                       got;

	always #12.5 sys_clk = ~sys_clk;

	jtag_flash_access u_dut (.sys_clk(sys_clk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdo_en_n(tdo_en_n), .flash_valid(flash_valid), .flash_req(flash_req),
		.flash_rsp(flash_rsp));
	flash_model u_flash (.clk(sys_clk), .rstn(rstn), .delay(delay), .flash_valid(flash_valid),
		.flash_req(flash_req), .flash_rsp(flash_rsp));

	// ==========================================
	// Checking
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic check(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : check

	task automatic print_verdict();
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : print_verdict

	always @(got) check(seen, exp_q.pop_front());

	// ==========================================
	// Tester
	// One tck period; tdo taken just before the rise
	task automatic cyc(input logic m, input logic d, output logic q);
		tms <= m;
		tdi <= d;
		tck <= 1'b0;
		repeat (4) @(posedge sys_clk);
		q = tdo;
		tck <= 1'b1;
		repeat (4) @(posedge sys_clk);
	endtask : cyc

	task automatic scan(input logic ir, input int n, input logic [31:0] v);
		logic q;
		o = 32'h0;
		cyc(1'b1, 1'b0, q);
		if (ir) cyc(1'b1, 1'b0, q);
		cyc(1'b0, 1'b0, q);
		cyc(1'b0, 1'b0, q);
		for (int i = 0; i < n; i++) begin
			cyc(i == n - 1, v[i], q);
			o[i] = q;
		end
		check(tdo_en_n, 1'b0);
		cyc(1'b1, 1'b0, q);
		cyc(1'b0, 1'b0, q);
		check(tdo_en_n, 1'b1);
	endtask : scan

	task automatic wait_idle();
		scan(1'b0, 1, 32'h0);
		busy1 = o[0];
		for (int k = 0; k < 80 && o[0] !== 1'b0; k++) begin
			scan(1'b0, 1, 32'h0);
		end
		if (o[0] !== 1'b0) begin
			error_cnt++;
			print_verdict();
		end
	endtask : wait_idle

	task automatic dr_wr(input int w, input logic [17:0] val);
		scan(1'b0, w + 2, {14'h0, val} | (32'h3 << w));
	endtask : dr_wr

	task automatic reg_wr(input logic [15:0] irv, input int w, input logic [17:0] val);
		scan(1'b1, jtag_flash_pkg::IR_W, {16'h0, irv});
		dr_wr(w, val);
		wait_idle();
	endtask : reg_wr

	// Nine shifts of zeros stay a poll: busy then the byte
	task automatic reg_rd(input logic [15:0] irv, input logic [7:0] e);
		scan(1'b1, jtag_flash_pkg::IR_W, {16'h0, irv});
		scan(1'b0, 2, 32'h2);
		wait_idle();
		exp_q.push_back({23'h0, e, 1'b0});
		scan(1'b0, 9, 32'h0);
		seen = o;
		-> got;
	endtask : reg_rd

	// ==========================================
	// Sequence
	initial begin
		repeat (5) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge sys_clk);
		cyc(1'b0, 1'b0, busy1);
		exp_q.push_back({jtag_flash_pkg::ID_VERSION, jtag_flash_pkg::ID_PART,
			jtag_flash_pkg::ID_MAKER, jtag_flash_pkg::ID_MARK});
		scan(1'b0, 32, 32'h0);
		seen = o;
		-> got;
		rnd = lfsr(rnd);
		b0 = rnd[7:0];
		b1 = rnd[15:8];
		delay <= rnd[23:16];
		reg_wr(CON, 8, 18'h090);
		reg_rd(CON, 8'h90);
		reg_wr(ADR, 16, 18'h0010);
		reg_wr(DAT, 8, {10'h0, b0});
		check(busy1, 1'b1);
		check(u_flash.last_req, {jtag_flash_pkg::FC_PROG, 16'h0010, b0, 1'b1});
		reg_wr(CON, 8, 18'h010);
		reg_wr(DAT, 8, {10'h0, b1});
		check(u_flash.last_req, {jtag_flash_pkg::FC_PROG, 16'h0011, b1, 1'b0});
		n0 = u_flash.req_cnt;
		reg_wr(CON, 8, 18'h000);
		reg_wr(DAT, 8, 18'h05a);
		reg_rd(DAT, 8'h5a);
		check(u_flash.req_cnt, n0);
		reg_wr(CON, 8, 18'h001);
		reg_wr(ADR, 16, 18'h0010);
		reg_rd(DAT, 8'h5a);
		reg_rd(DAT, b0);
		reg_rd(DAT, b1);
		// Opcode 01 is still a poll, even in block read mode
		n0 = u_flash.req_cnt;
		scan(1'b0, 2, 32'h1);
		wait_idle();
		check(u_flash.req_cnt, n0);
		check(u_flash.last_req.addr, 16'h0012);
		reg_wr(CON, 8, 18'h002);
		n0 = u_flash.req_cnt;
		reg_rd(DAT, 8'h7e);
		check(u_flash.req_cnt, n0);
		reg_rd(DAT, 8'h7e);
		check(u_flash.req_cnt, n0 + 1);
		// Long flash wait so the second write lands while busy
		delay <= 8'hff;
		reg_wr(CON, 8, 18'h010);
		reg_wr(ADR, 16, 18'h0040);
		scan(1'b1, jtag_flash_pkg::IR_W, {16'h0, DAT});
		n0 = u_flash.req_cnt;
		dr_wr(8, {10'h0, b0});
		dr_wr(8, {10'h0, b1});
		check(u_flash.req_cnt, n0 + 1);
		wait_idle();
		wait_idle();
		check(u_flash.last_req, {jtag_flash_pkg::FC_PROG, 16'h0041, b1, 1'b0});
		reg_wr(CON, 8, 18'h020);
		n0 = u_flash.req_cnt;
		reg_wr(DAT, 8, 18'h000);
		check(u_flash.req_cnt, n0);
		reg_wr(DAT, 8, 18'h0a5);
		reg_wr(DAT, 8, 18'h0a5);
		check(u_flash.last_req.addr, 16'h0042);
		check(u_flash.last_req.cmd, jtag_flash_pkg::FC_ERASE);
		reg_wr(ADR, 16, 18'h0fdff);
		reg_wr(DAT, 8, 18'h0a5);
		check(u_flash.last_req.cmd, jtag_flash_pkg::FC_ERASE_ALL);
		print_verdict();
	end
endmodule : test_jtag_flash_access

`default_nettype wire
